// ===== inc/pbo_pkg.sv
package pbo_pkg;
   // ==========================================================
   // Register offsets (printed offsets not all multiples of 4)
   // ==========================================================
   localparam logic [7:0] IDX_PORT_B_OUTPUT_LATCH = 8'h18;
   localparam logic [7:0] IDX_PORT_A_INPUT_LEVELS = 8'h19;
   localparam logic [7:0] IDX_PORT_A_DIRECTION    = 8'h1a;
   localparam logic [7:0] IDX_PORT_A_OUTPUT_LATCH = 8'h1b;
   localparam logic [7:0] IDX_CORE_CONTROL        = 8'h35;
   localparam logic [7:0] IDX_PORT_B_DIRECTION    = 8'h17;
   localparam logic [7:0] IDX_PORT_B_INPUT_LEVELS = 8'h16;
   localparam logic [7:0] IDX_ALT_CONTROL         = 8'h40;
   localparam logic [7:0] IDX_ALT_STATUS          = 8'h41;

   // ==========================================================
   // Reset values and field positions
   // ==========================================================
   localparam logic [7:0] RST_LATCH     = 8'h00;
   localparam logic [7:0] RST_DIRECTION = 8'h00;
   localparam logic [7:0] RST_CORE      = 8'h00;
   localparam logic [7:0] RST_ALT       = 8'h00;
   localparam int         CORE_PU_OFF   = 6;
   localparam logic [7:0] CORE_RO_MASK  = 8'h03;
   // Alt control bits
   localparam int ALT_PORT_SELECT   = 0;
   localparam int ALT_TWO_WIRE      = 1;
   localparam int ALT_THREE_WIRE    = 2;
   localparam int ALT_START_IRQ_EN  = 3;
   localparam int ALT_PCIE          = 4;

   // Per-pin override bundle
   typedef struct packed {
      logic [7:0] pu_oe;
      logic [7:0] pu_ov;
      logic [7:0] dd_oe;
      logic [7:0] dd_ov;
      logic [7:0] pv_oe;
      logic [7:0] pv_ov;
      logic [7:0] pt_oe;
      logic [7:0] die_oe;
      logic [7:0] die_ov;
   } pbo_ovr_t;

   // Peripheral signals entering the override logic
   typedef struct packed {
      logic       serial_data_out;
      logic       serial_clock_hold;
      logic       serial_clock_toggle;
      logic       sda_drive;
      logic       timer1_compare_a_out;
      logic       timer1_compare_a_en;
      logic       timer1_compare_b_out;
      logic       timer1_compare_b_en;
      logic       timer1_compare_d_out;
      logic       timer1_compare_d_en;
      logic       debug_tx;
      logic [7:0] adc_dig_disable;
   } pbo_periph_t;

   // Fuse states; the reset-disable and debug fuses read 0 when programmed
   typedef struct packed {
      logic reset_pin_disable_fuse;
      logic debug_link_fuse;
      logic lock_bits_programmed;
      logic internal_osc_selected;
      logic external_clock_selected;
   } pbo_fuse_t;
endpackage : pbo_pkg

// ===== rtl/pbo_pin_cell.sv
`timescale 1ns/1ps
// ==========================================================
// One port pin: overrides applied over register values
// ==========================================================
module pbo_pin_cell (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic pin_direction_bit,
   input  wire logic pin_output_bit,
   input  wire logic pull_up_disable,
   input  wire logic pu_oe,
   input  wire logic pu_ov,
   input  wire logic dd_oe,
   input  wire logic dd_ov,
   input  wire logic pv_oe,
   input  wire logic pv_ov,
   input  wire logic pt_oe,
   input  wire logic die_oe,
   input  wire logic die_ov,
   input  wire logic pad_in,
   output logic      pad_out,
   output logic      pad_oe,
   output logic      pad_pullup,
   output logic      pin_level
);
   logic dir_eff;
   logic val_eff;
   logic din_en;
   logic sync1_ff;
   logic sync2_ff;

   // Override enable takes priority over register value
   assign dir_eff    = dd_oe ? dd_ov : pin_direction_bit;
   assign val_eff    = pv_oe ? pv_ov : pin_output_bit;
   assign pad_out    = pt_oe ? ~pin_output_bit : val_eff;
   assign pad_oe     = dir_eff;
   // Pull-up override bypasses the global disable, as debug needs it
   assign pad_pullup = pu_oe ? pu_ov
                     : (~pin_direction_bit & pin_output_bit & ~pull_up_disable);
   // Digital input enabled unless overridden off
   assign din_en     = die_oe ? die_ov : 1'b1;

   // Two-stage sampler; first stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
      end else begin
         sync1_ff <= pad_in & din_en;
         sync2_ff <= sync1_ff;
      end
   end
   assign pin_level = sync2_ff;
endmodule : pbo_pin_cell

// ===== rtl/pbo_port.sv
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
// Operation
// - Three-wire: serial data out drives pin 1
// - Pin 1 latch still enables pull-up
// - Pin 0 serial input needs input direction
// - Pin 2 outputs inverted compare B
// - Pin 1 outputs compare A ORed serial
// - Pin 0 outputs inverted compare A
// - Pin 7 debug: pull-up, debug direction
// - Two-wire pin 2 open-drain clock direction
// - Pin 0 value override: compare A
// - Oscillator overrides on pins 4 and 5
// - Global pull-up disable kills pull-ups except pin 7 in debug
// - Pin 2 serial clock and toggle
// - Pin 2 input kept for start detect
// - Pin 0 input kept for start detect
// - Reset-disable fuse makes pin 7 plain I/O
// - Debug fuse: pin 7 open-drain wired-AND
module pbo_port (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   input  wire logic [3:0]           pstrb,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire pbo_pkg::pbo_periph_t periph,
   input  wire pbo_pkg::pbo_fuse_t   fuses,
   input  wire logic [7:0]           port_b_in,
   output logic      [7:0]           port_b_out,
   output logic      [7:0]           port_b_oe,
   output logic      [7:0]           port_b_pullup,
   output logic      [7:0]           port_b_level,
   input  wire logic [7:0]           port_a_in,
   output logic      [7:0]           port_a_out,
   output logic      [7:0]           port_a_oe,
   output logic      [7:0]           port_a_pullup,
   output logic                      reset_pin_active,
   output logic                      serial_ctl_port_select,
   output logic                      serial_ctl_start_irq_en
);
   // ==========================================================
   // Registers
   // ==========================================================
   logic [7:0] port_b_latch_ff;
   logic [7:0] port_b_dir_ff;
   logic [7:0] port_a_latch_ff;
   logic [7:0] port_a_dir_ff;
   logic [7:0] core_ctl_ff;
   logic [7:0] alt_ctl_ff;
   logic [7:0] port_a_level;
   logic [7:0] pb_level;
   logic [7:0] nxt_rdata;
   logic       wr_en;
   logic       rd_en;
   logic       addr_ok;
   logic [7:0] idx;
   logic       pull_up_disable;
   logic       serial_port_select;
   logic       serial_two_wire_active;
   logic       serial_three_wire_active;
   logic       serial_start_irq_enable;
   logic       pcie;
   logic       rst_dis;
   logic       dbg_en;
   logic       osc_int;
   logic       osc_ext;
   pbo_pkg::pbo_ovr_t ovb;
   pbo_pkg::pbo_ovr_t ova;

   assign idx     = paddr[9:2];
   assign wr_en   = psel & penable & pwrite;
   assign rd_en   = psel & ~pwrite;
   assign pready  = 1'b1;                    // Zero wait states
   assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00)
                 && (idx == pbo_pkg::IDX_PORT_B_OUTPUT_LATCH
                  || idx == pbo_pkg::IDX_PORT_A_INPUT_LEVELS
                  || idx == pbo_pkg::IDX_PORT_A_DIRECTION
                  || idx == pbo_pkg::IDX_PORT_A_OUTPUT_LATCH
                  || idx == pbo_pkg::IDX_CORE_CONTROL
                  || idx == pbo_pkg::IDX_PORT_B_DIRECTION
                  || idx == pbo_pkg::IDX_PORT_B_INPUT_LEVELS
                  || idx == pbo_pkg::IDX_ALT_CONTROL
                  || idx == pbo_pkg::IDX_ALT_STATUS);
   assign pslverr = psel & penable & ~addr_ok;

   // Register writes; only byte lane 0 carries data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_b_latch_ff <= pbo_pkg::RST_LATCH;
         port_b_dir_ff   <= pbo_pkg::RST_DIRECTION;
         port_a_latch_ff <= pbo_pkg::RST_LATCH;
         port_a_dir_ff   <= pbo_pkg::RST_DIRECTION;
         core_ctl_ff     <= pbo_pkg::RST_CORE;
         alt_ctl_ff      <= pbo_pkg::RST_ALT;
      end else if (wr_en && addr_ok && pstrb[0]) begin
         case (idx)
            pbo_pkg::IDX_PORT_B_OUTPUT_LATCH: port_b_latch_ff <= pwdata[7:0];
            pbo_pkg::IDX_PORT_A_DIRECTION:    port_a_dir_ff   <= pwdata[7:0];
            pbo_pkg::IDX_PORT_A_OUTPUT_LATCH: port_a_latch_ff <= pwdata[7:0];
            pbo_pkg::IDX_PORT_B_DIRECTION:    port_b_dir_ff   <= pwdata[7:0];
            // Writing a one to an input register toggles the latch
            pbo_pkg::IDX_PORT_A_INPUT_LEVELS: port_a_latch_ff <= port_a_latch_ff ^ pwdata[7:0];
            pbo_pkg::IDX_PORT_B_INPUT_LEVELS: port_b_latch_ff <= port_b_latch_ff ^ pwdata[7:0];
            // Low two bits are read-only
            pbo_pkg::IDX_CORE_CONTROL: core_ctl_ff <= pwdata[7:0] & ~pbo_pkg::CORE_RO_MASK;
            pbo_pkg::IDX_ALT_CONTROL:  alt_ctl_ff  <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // Read mux
   always_comb begin
      nxt_rdata = 8'h00;
      case (idx)
         pbo_pkg::IDX_PORT_B_OUTPUT_LATCH: nxt_rdata = port_b_latch_ff;
         pbo_pkg::IDX_PORT_A_INPUT_LEVELS: nxt_rdata = port_a_level;
         pbo_pkg::IDX_PORT_A_DIRECTION:    nxt_rdata = port_a_dir_ff;
         pbo_pkg::IDX_PORT_A_OUTPUT_LATCH: nxt_rdata = port_a_latch_ff;
         pbo_pkg::IDX_CORE_CONTROL:        nxt_rdata = core_ctl_ff;
         pbo_pkg::IDX_PORT_B_DIRECTION:    nxt_rdata = port_b_dir_ff;
         pbo_pkg::IDX_PORT_B_INPUT_LEVELS: nxt_rdata = pb_level;
         pbo_pkg::IDX_ALT_CONTROL:         nxt_rdata = alt_ctl_ff;
         pbo_pkg::IDX_ALT_STATUS:          nxt_rdata = {6'h00, dbg_en, rst_dis};
         default:                          nxt_rdata = 8'h00;
      endcase
   end
   // Read data is a flop loaded in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_en && !penable) begin
         prdata <= {24'h00_0000, nxt_rdata};
      end
   end

   // ==========================================================
   // Control terms (reset and debug fuse terms true when fuse reads 0)
   // ==========================================================
   assign pull_up_disable          = core_ctl_ff[pbo_pkg::CORE_PU_OFF];
   assign serial_port_select       = alt_ctl_ff[pbo_pkg::ALT_PORT_SELECT];
   assign serial_two_wire_active   = alt_ctl_ff[pbo_pkg::ALT_TWO_WIRE];
   assign serial_three_wire_active = alt_ctl_ff[pbo_pkg::ALT_THREE_WIRE];
   assign serial_start_irq_enable  = alt_ctl_ff[pbo_pkg::ALT_START_IRQ_EN];
   assign pcie                     = alt_ctl_ff[pbo_pkg::ALT_PCIE];
   assign rst_dis  = ~fuses.reset_pin_disable_fuse;
   assign dbg_en   = ~fuses.debug_link_fuse & ~fuses.lock_bits_programmed;
   assign osc_int  = fuses.internal_osc_selected;
   assign osc_ext  = fuses.external_clock_selected;
   // Reset circuit owns pin 7 unless the disable fuse is programmed
   assign reset_pin_active        = ~rst_dis;
   assign serial_ctl_port_select  = serial_port_select;
   assign serial_ctl_start_irq_en = serial_start_irq_enable;

   // ==========================================================
   // Port B override table
   // ==========================================================
   always_comb begin
      ovb = '0;
      // Pin 0: inverted compare A, two-wire data line
      ovb.dd_oe[0]  = serial_two_wire_active & serial_port_select;
      ovb.dd_ov[0]  = (periph.sda_drive | port_b_latch_ff[0]) & port_b_dir_ff[0]
                    & serial_port_select;
      ovb.pv_oe[0]  = periph.timer1_compare_a_en
                    | (serial_two_wire_active & port_b_dir_ff[0]
                       & serial_port_select);
      ovb.pv_ov[0]  = ~periph.timer1_compare_a_out;
      // Three-wire data input does not override direction
      ovb.die_oe[0] = (pcie & port_b_latch_ff[0])
                    | (serial_start_irq_enable & serial_port_select);
      ovb.die_ov[0] = 1'b1;
      // Pin 1: compare A, three-wire data out
      ovb.pv_oe[1]  = periph.timer1_compare_a_en
                    | (serial_port_select & serial_three_wire_active);
      ovb.pv_ov[1]  = periph.timer1_compare_a_out
                    | (periph.serial_data_out & serial_port_select);
      // Pull-up on pin 1 still follows latch and direction
      ovb.pu_oe[1]  = 1'b0;
      // Pin 2: inverted compare B, serial clock
      ovb.dd_oe[2]  = serial_two_wire_active & serial_port_select;
      ovb.dd_ov[2]  = (periph.serial_clock_hold | port_b_latch_ff[2])
                    & port_b_dir_ff[2] & serial_port_select;
      ovb.pv_oe[2]  = periph.timer1_compare_b_en
                    | (serial_port_select & serial_two_wire_active
                       & port_b_dir_ff[2]);
      ovb.pv_ov[2]  = ~periph.timer1_compare_b_out;
      ovb.pt_oe[2]  = periph.serial_clock_toggle & serial_port_select;
      ovb.die_oe[2] = (pcie & port_b_latch_ff[2])
                    | (serial_start_irq_enable & serial_port_select);
      ovb.die_ov[2] = 1'b1;
      // Pin 3: compare B
      ovb.pv_oe[3]  = periph.timer1_compare_b_en;
      ovb.pv_ov[3]  = periph.timer1_compare_b_out;
      // Pin 4: oscillator input, inverted compare D
      ovb.pu_oe[4]  = osc_int;
      ovb.dd_oe[4]  = osc_int;
      ovb.pv_oe[4]  = periph.timer1_compare_d_en;
      ovb.pv_ov[4]  = ~periph.timer1_compare_d_out;
      ovb.die_oe[4] = osc_int | periph.adc_dig_disable[4];
      ovb.die_ov[4] = ~(osc_int & periph.adc_dig_disable[4]);
      // Pin 5: oscillator output, compare D
      ovb.pu_oe[5]  = osc_int & osc_ext;
      ovb.dd_oe[5]  = osc_int & osc_ext;
      ovb.pv_oe[5]  = periph.timer1_compare_d_en;
      ovb.pv_ov[5]  = periph.timer1_compare_d_out;
      ovb.die_oe[5] = (osc_int & osc_ext) | periph.adc_dig_disable[5];
      ovb.die_ov[5] = ~((osc_int & osc_ext) | periph.adc_dig_disable[5]);
      // Pin 6: plain input sources
      ovb.die_oe[6] = rst_dis | periph.adc_dig_disable[6];
      ovb.die_ov[6] = ~periph.adc_dig_disable[6];
      // Pin 7: debug link, open drain with pull-up forced
      ovb.pu_oe[7]  = rst_dis & dbg_en;
      ovb.pu_ov[7]  = 1'b1;
      ovb.dd_oe[7]  = rst_dis & dbg_en;
      ovb.dd_ov[7]  = periph.debug_tx;
      ovb.pv_oe[7]  = rst_dis & dbg_en;
      ovb.pv_ov[7]  = 1'b0;
   end

   // Port A uses register values only
   always_comb begin
      ova = '0;
   end

   // ==========================================================
   // Pin cells
   // ==========================================================
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_pin
         pbo_pin_cell u_b (
            .pclk              (pclk),
            .presetn           (presetn),
            .pin_direction_bit (port_b_dir_ff[g]),
            .pin_output_bit    (port_b_latch_ff[g]),
            .pull_up_disable   (pull_up_disable),
            .pu_oe             (ovb.pu_oe[g]),
            .pu_ov             (ovb.pu_ov[g]),
            .dd_oe             (ovb.dd_oe[g]),
            .dd_ov             (ovb.dd_ov[g]),
            .pv_oe             (ovb.pv_oe[g]),
            .pv_ov             (ovb.pv_ov[g]),
            .pt_oe             (ovb.pt_oe[g]),
            .die_oe            (ovb.die_oe[g]),
            .die_ov            (ovb.die_ov[g]),
            .pad_in            (port_b_in[g]),
            .pad_out           (port_b_out[g]),
            .pad_oe            (port_b_oe[g]),
            .pad_pullup        (port_b_pullup[g]),
            .pin_level         (pb_level[g])
         );
         pbo_pin_cell u_a (
            .pclk              (pclk),
            .presetn           (presetn),
            .pin_direction_bit (port_a_dir_ff[g]),
            .pin_output_bit    (port_a_latch_ff[g]),
            .pull_up_disable   (pull_up_disable),
            .pu_oe             (ova.pu_oe[g]),
            .pu_ov             (ova.pu_ov[g]),
            .dd_oe             (ova.dd_oe[g]),
            .dd_ov             (ova.dd_ov[g]),
            .pv_oe             (ova.pv_oe[g]),
            .pv_ov             (ova.pv_ov[g]),
            .pt_oe             (ova.pt_oe[g]),
            .die_oe            (ova.die_oe[g]),
            .die_ov            (ova.die_ov[g]),
            .pad_in            (port_a_in[g]),
            .pad_out           (port_a_out[g]),
            .pad_oe            (port_a_oe[g]),
            .pad_pullup        (port_a_pullup[g]),
            .pin_level         (port_a_level[g])
         );
      end
   endgenerate
   assign port_b_level = pb_level;
endmodule : pbo_port

// ===== verification/pbo_port_properties.sv
`timescale 1ns/1ps
// ==========================================================
// Pin override relations seen at the port boundary
// ==========================================================
module pbo_port_chk (
   input wire logic                 pclk,
   input wire logic                 presetn,
   input wire logic                 pslverr,
   input wire pbo_pkg::pbo_periph_t periph,
   input wire pbo_pkg::pbo_fuse_t   fuses,
   input wire logic [7:0]           port_b_in,
   input wire logic [7:0]           port_b_out,
   input wire logic [7:0]           port_b_oe,
   input wire logic [7:0]           port_b_pullup,
   input wire logic [7:0]           port_b_level,
   input wire logic                 serial_ctl_port_select
);
   logic [1:0] up_ff;
   logic       dbg_on;

   // Synchronizer holds reset values for two edges, so wait before comparing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) up_ff <= 2'h0;
      else if (up_ff != 2'h3) up_ff <= up_ff + 2'h1;
   end

   // Debug link owns pin 7 only with both fuses programmed and no lock
   assign dbg_on = !fuses.reset_pin_disable_fuse && !fuses.debug_link_fuse
                   && !fuses.lock_bits_programmed;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_dbg_pullup: assert property (
      dbg_on |-> port_b_pullup[7]) else $error("pin 7 pull-up off in debug mode");
   a_dbg_dir: assert property (
      dbg_on |-> port_b_oe[7] == periph.debug_tx) else $error("pin 7 direction wrong");
   a_osc_pin4: assert property (
      fuses.internal_osc_selected |-> !port_b_pullup[4] && !port_b_oe[4])
      else $error("pin 4 not released to oscillator");
   a_osc_pin5: assert property (
      fuses.internal_osc_selected && fuses.external_clock_selected
      |-> !port_b_pullup[5] && !port_b_oe[5]) else $error("pin 5 not released");
   a_cmpb_pin2: assert property (
      periph.timer1_compare_b_en && port_b_oe[2]
      && !(periph.serial_clock_toggle && serial_ctl_port_select)
      |-> port_b_out[2] == ~periph.timer1_compare_b_out) else $error("pin 2 compare b");
   a_cmpa_pin1: assert property (
      periph.timer1_compare_a_en && port_b_oe[1] |-> port_b_out[1] ==
      (periph.timer1_compare_a_out | (periph.serial_data_out & serial_ctl_port_select)))
      else $error("pin 1 compare a");
   a_cmpa_pin0: assert property (
      periph.timer1_compare_a_en && port_b_oe[0]
      |-> port_b_out[0] == ~periph.timer1_compare_a_out) else $error("pin 0 compare a");
   a_level_sync: assert property (
      up_ff == 2'h3 && !fuses.reset_pin_disable_fuse && !periph.adc_dig_disable[7]
      |-> port_b_level[7] == $past(port_b_in[7], 2)) else $error("pin 7 level lag");

   c_toggle: cover property (periph.serial_clock_toggle && serial_ctl_port_select);
   c_hold: cover property (periph.serial_clock_hold && port_b_oe[2]);
   c_err: cover property (pslverr);
endmodule : pbo_port_chk

// ===== verification/pbo_pad_model.sv
`timescale 1ns/1ps
// ==========================================================
// Board side of the eight pins
// ==========================================================
module pbo_pad_model (
   input wire logic       pclk,
   input wire logic [7:0] pad_out,
   input wire logic [7:0] pad_oe,
   input wire logic [7:0] pad_pullup,
   input wire logic [7:0] ext_en,
   input wire logic [7:0] ext_val,
   output logic     [7:0] pad_lvl
);
   logic flt_ff = 1'b0;

   // An undriven pin without pull-up wanders, so stale levels never pass
   always_ff @(posedge pclk) flt_ff <= ~flt_ff;

   // Drivers meet wired-AND; then pull-up, then floating
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pad_oe[i] && ext_en[i]) pad_lvl[i] = pad_out[i] & ext_val[i];
         else if (pad_oe[i]) pad_lvl[i] = pad_out[i];
         else if (ext_en[i]) pad_lvl[i] = ext_val[i];
         else pad_lvl[i] = pad_pullup[i] | flt_ff;
      end
   end
endmodule : pbo_pad_model

// ===== verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic                 pclk = 1'b0;
   logic                 presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0]          paddr;
   logic [31:0]          pwdata, prdata, r;
   pbo_pkg::pbo_periph_t periph;
   pbo_pkg::pbo_fuse_t   fuses;
   logic [7:0]           pb_in, pb_out, pb_oe, pb_pu, pb_lvl, ext_en, ext_val, pa_in;
   logic                 psel_o, start_en;
   int                   err_count = 0;
   int                   samples_checked = 0;
   logic [32:0]          rd_q[$];
   logic [17:0]          pin_q[$];
   logic [17:0]          pe;
   event                 snap;

   initial forever #20 pclk = ~pclk;

   pbo_port u_pbo_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .periph(periph), .fuses(fuses),
      .port_b_in(pb_in), .port_b_out(pb_out), .port_b_oe(pb_oe), .port_b_pullup(pb_pu),
      .port_b_level(pb_lvl), .port_a_in(pa_in), .port_a_out(), .port_a_oe(),
      .port_a_pullup(), .reset_pin_active(), .serial_ctl_port_select(psel_o),
      .serial_ctl_start_irq_en(start_en));

   pbo_pad_model u_pbo_pad_model (.pclk(pclk), .pad_out(pb_out), .pad_oe(pb_oe),
      .pad_pullup(pb_pu), .ext_en(ext_en), .ext_val(ext_val), .pad_lvl(pb_in));

   task automatic chk(input logic [32:0] act, input logic [32:0] exp);
      samples_checked++;
      if (act !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, act, exp);
      end
   endtask : chk

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : tally_and_finish

   // One APB transfer; waits on pready with a bound
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         err_count++;
         tally_and_finish();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic err);
      rd_q.push_back({err, 24'h0, e});
      apb(1'b0, idx, 8'h00);
   endtask : rd

   // Pin outputs are combinational: look mid-cycle, then resume on an edge
   task automatic pin(input logic [1:0] s, input logic [7:0] m, input logic [7:0] e);
      @(negedge pclk);
      pin_q.push_back({s, m, e});
      ->snap;
      @(posedge pclk);
   endtask : pin

   // ==========================================================
   // Monitors: oldest note against what appears
   // ==========================================================
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite && rd_q.size() > 0)
         chk({pslverr, prdata}, rd_q.pop_front());
   end

   always @(snap) begin
      pe = pin_q.pop_front();
      case (pe[17:16])
         2'h0: chk({25'h0, pb_out & pe[15:8]}, {25'h0, pe[7:0] & pe[15:8]});
         2'h1: chk({25'h0, pb_oe & pe[15:8]}, {25'h0, pe[7:0] & pe[15:8]});
         2'h2: chk({25'h0, pb_pu & pe[15:8]}, {25'h0, pe[7:0] & pe[15:8]});
         default: chk({25'h0, pb_lvl & pe[15:8]}, {25'h0, pe[7:0] & pe[15:8]});
      endcase
   end

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      void'($urandom(32'h7629));
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      periph = '0;
      fuses = 5'h18;
      {ext_en, ext_val} = 16'h0000;
      pa_in = 8'h00;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      pa_in <= 8'h5a;
      rd(pbo_pkg::IDX_PORT_B_OUTPUT_LATCH, 8'h00, 1'b0);
      rd(pbo_pkg::IDX_PORT_A_OUTPUT_LATCH, 8'h00, 1'b0);
      rd(pbo_pkg::IDX_CORE_CONTROL, 8'h00, 1'b0);
      r = $urandom;
      apb(1'b1, pbo_pkg::IDX_PORT_A_DIRECTION, r[7:0]);
      rd(pbo_pkg::IDX_PORT_A_DIRECTION, r[7:0], 1'b0);
      apb(1'b1, pbo_pkg::IDX_CORE_CONTROL, 8'hff);
      rd(pbo_pkg::IDX_CORE_CONTROL, 8'hfc, 1'b0);
      rd(8'h20, 8'h00, 1'b1);
      $display("test 1 done");
      apb(1'b1, pbo_pkg::IDX_CORE_CONTROL, 8'h00);
      apb(1'b1, pbo_pkg::IDX_PORT_B_OUTPUT_LATCH, 8'hff);
      pin(2'h2, 8'h7f, 8'h7f);
      apb(1'b1, pbo_pkg::IDX_CORE_CONTROL, 8'h40);
      pin(2'h2, 8'h7f, 8'h00);
      apb(1'b1, pbo_pkg::IDX_CORE_CONTROL, 8'h00);
      fuses <= 5'h03;
      periph.debug_tx <= 1'b1;
      pin(2'h2, 8'hb0, 8'h80);
      apb(1'b1, pbo_pkg::IDX_PORT_B_DIRECTION, 8'hff);
      pin(2'h1, 8'hb0, 8'h80);
      periph.debug_tx <= 1'b0;
      apb(1'b1, pbo_pkg::IDX_CORE_CONTROL, 8'h40);
      pin(2'h1, 8'h80, 8'h00);
      pin(2'h2, 8'h80, 8'h80);
      apb(1'b1, pbo_pkg::IDX_CORE_CONTROL, 8'h00);
      fuses <= 5'h18;
      $display("test 2 done");
      apb(1'b1, pbo_pkg::IDX_PORT_B_DIRECTION, 8'h07);
      periph.timer1_compare_a_en <= 1'b1;
      periph.timer1_compare_b_en <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         r = $urandom;
         apb(1'b1, pbo_pkg::IDX_ALT_CONTROL, (i > 3) ? 8'h05 : 8'h00);
         periph.timer1_compare_a_out <= r[0];
         periph.timer1_compare_b_out <= r[1];
         periph.serial_data_out <= r[2];
         pin(2'h0, 8'h07, {5'h0, ~r[1], r[0] | (r[2] & (i > 3)), ~r[0]});
      end
      periph.timer1_compare_a_en <= 1'b0;
      periph.timer1_compare_b_en <= 1'b0;
      periph.serial_data_out <= 1'b1;
      apb(1'b1, pbo_pkg::IDX_PORT_B_OUTPUT_LATCH, 8'h00);
      apb(1'b1, pbo_pkg::IDX_PORT_B_DIRECTION, 8'h02);
      pin(2'h0, 8'h02, 8'h02);
      pin(2'h1, 8'h01, 8'h00);
      apb(1'b1, pbo_pkg::IDX_PORT_B_DIRECTION, 8'h00);
      apb(1'b1, pbo_pkg::IDX_PORT_B_OUTPUT_LATCH, 8'h02);
      pin(2'h2, 8'h02, 8'h02);
      $display("test 3 done");
      apb(1'b1, pbo_pkg::IDX_ALT_CONTROL, 8'h03);
      apb(1'b1, pbo_pkg::IDX_PORT_B_DIRECTION, 8'h04);
      apb(1'b1, pbo_pkg::IDX_PORT_B_OUTPUT_LATCH, 8'h00);
      periph.serial_clock_hold <= 1'b1;
      pin(2'h1, 8'h04, 8'h04);
      periph.serial_clock_hold <= 1'b0;
      pin(2'h1, 8'h04, 8'h00);
      apb(1'b1, pbo_pkg::IDX_PORT_B_OUTPUT_LATCH, 8'h04);
      pin(2'h1, 8'h04, 8'h04);
      apb(1'b1, pbo_pkg::IDX_ALT_CONTROL, 8'h05);
      apb(1'b1, pbo_pkg::IDX_PORT_B_OUTPUT_LATCH, 8'h00);
      periph.serial_clock_toggle <= 1'b1;
      pin(2'h0, 8'h04, 8'h04);
      periph.serial_clock_toggle <= 1'b0;
      $display("test 4 done");
      apb(1'b1, pbo_pkg::IDX_ALT_CONTROL, 8'h00);
      apb(1'b1, pbo_pkg::IDX_PORT_B_DIRECTION, 8'h00);
      fuses <= 5'h08;
      r = $urandom;
      ext_en <= 8'hff;
      ext_val <= r[7:0];
      repeat (3) @(posedge pclk);
      pin(2'h3, 8'hff, r[7:0]);
      rd(pbo_pkg::IDX_PORT_B_INPUT_LEVELS, r[7:0], 1'b0);
      $display("test 5 done");
      tally_and_finish();
   end

endmodule : tb_top

bind pbo_port pbo_port_chk u_pbo_port_chk (.pclk(pclk), .presetn(presetn),
   .pslverr(pslverr), .periph(periph), .fuses(fuses), .port_b_in(port_b_in),
   .port_b_out(port_b_out), .port_b_oe(port_b_oe), .port_b_pullup(port_b_pullup),
   .port_b_level(port_b_level), .serial_ctl_port_select(serial_ctl_port_select));
